// [hw/crst_register_selftest.v]
// register pattern self-test sequencer with the registers under test
// assumes caller blocks interrupts and selects bank zero before starting
//
// Behaviour
// - all four pairs in all four banks
// - pairs: write 5555, check, aaaa, check
// - status word: 55 then aa, compared
// - stack pointer: 5555 then aaaa, compared
// - every pattern write read back; mismatch fails
// - save original, restore after sequence
// - result 0 pass, 1 fail
// - code extension: 05, 0a; upper nibble zero
// - data extension: 05, 0a; low nibble only
`timescale 1ns/100ps
`include "crst_selftest_map.vh"
module crst_register_selftest (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] startReq,
  input wire intBlocked,
  input wire bankZeroSelect,
  output reg [4:0] testDone,
  output reg [4:0] testFail,
  output reg [7:0] accumulatorResult,
  output wire busy,
  output reg [7:0] statusWord,
  output reg [15:0] stackPointer,
  output reg [7:0] codeExtensionReg,
  output reg [7:0] dataExtensionReg
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam IDLE = 3'h0;
  localparam SAVE = 3'h1;
  localparam WRITE = 3'h2;
  localparam READ = 3'h3;
  localparam CHECK = 3'h4;
  localparam RESTORE = 3'h5;
  localparam FINISH = 3'h6;

  // ----------------------------------------
  // sequencer state and captured values
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] group;
  reg [3:0] pairIdx;
  reg patPhase;
  reg failSeen;
  reg [15:0] saved;
  reg [15:0] pattern;
  reg [15:0] regValue;
  reg [2:0] grantGroup;
  reg grantValid;
  integer i;

  wire [15:0] workRead;
  reg workWe;
  reg [15:0] workData;

  assign busy = (state != IDLE);

  // ----------------------------------------
  // start arbitration
  // ----------------------------------------
  // lowest numbered start wins when several arrive together
  always @* begin
    grantGroup = 3'h0;
    grantValid = 1'b0;
    for (i = `CRST_NUM_GRP - 1; i >= 0; i = i - 1) begin
      if (startReq[i]) begin
        grantGroup = i[2:0];
        grantValid = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pattern and readback selection
  // ----------------------------------------
  always @* begin
    case (group)
      `CRST_GRP_WORK: pattern = patPhase ? `CRST_PAT16_B : `CRST_PAT16_A;
      `CRST_GRP_PSW: pattern = {8'h00, patPhase ? `CRST_PAT8_B : `CRST_PAT8_A};
      `CRST_GRP_STACK: pattern = patPhase ? `CRST_PAT16_B : `CRST_PAT16_A;
      `CRST_GRP_CS: pattern = {8'h00, patPhase ? `CRST_PATX_B : `CRST_PATX_A};
      `CRST_GRP_DEXT: pattern = {8'h00, patPhase ? `CRST_PATX_B : `CRST_PATX_A};
      default: pattern = 16'h0000;
    endcase
  end

  always @* begin
    case (group)
      `CRST_GRP_WORK: regValue = workRead;
      `CRST_GRP_PSW: regValue = {8'h00, statusWord};
      `CRST_GRP_STACK: regValue = stackPointer;
      `CRST_GRP_CS: regValue = {8'h00, codeExtensionReg};
      `CRST_GRP_DEXT: regValue = {8'h00, dataExtensionReg};
      default: regValue = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // working pair write path
  // ----------------------------------------
  // work pair writes come from pattern or restore
  always @* begin
    workWe = 1'b0;
    workData = pattern;
    if (group == `CRST_GRP_WORK) begin
      if (state == WRITE) begin
        workWe = 1'b1;
      end else if (state == RESTORE) begin
        workWe = 1'b1;
        workData = saved;
      end
    end
  end

  crst_work_regfile uWork (
    .clk_sys(clk_sys),
    .writeEn(workWe),
    .writeAddr(pairIdx),
    .writeData(workData),
    .readAddr(pairIdx),
    .readData(workRead)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      group <= 3'h0;
      pairIdx <= 4'h0;
      patPhase <= 1'b0;
      failSeen <= 1'b0;
      saved <= 16'h0000;
      testDone <= 5'h00;
      testFail <= 5'h00;
      accumulatorResult <= 8'h00;
      statusWord <= 8'h00;
      stackPointer <= 16'h0000;
      codeExtensionReg <= 8'h00;
      dataExtensionReg <= 8'h00;
    end else begin
      testDone <= 5'h00;
      case (state)
        IDLE: begin
          if (grantValid) begin
            group <= grantGroup;
            pairIdx <= 4'h0;
            patPhase <= 1'b0;
            // unblocked interrupts, or bank zero unselected for the work pairs, are reported as a failed test
            failSeen <= !intBlocked || (grantGroup == `CRST_GRP_WORK && !bankZeroSelect);
            state <= SAVE;
          end
        end
        SAVE: begin
          // work pair read data is one cycle late, so wait in save first
          state <= WRITE;
        end
        WRITE: begin
          // first pass only: the second would keep the first pattern
          if (!patPhase) begin
            saved <= regValue;
          end
          case (group)
            `CRST_GRP_PSW: statusWord <= pattern[7:0];
            `CRST_GRP_STACK: stackPointer <= pattern;
            // upper nibble hard-wired to zero
            `CRST_GRP_CS: codeExtensionReg <= pattern[7:0] & `CRST_EXT_MASK;
            `CRST_GRP_DEXT: dataExtensionReg <= pattern[7:0] & `CRST_EXT_MASK;
            default: ;
          endcase
          state <= READ;
        end
        READ: begin
          state <= CHECK;
        end
        CHECK: begin
          // fail is sticky until the next start
          if (regValue != pattern) begin
            failSeen <= 1'b1;
          end
          if (!patPhase) begin
            patPhase <= 1'b1;
            state <= WRITE;
          end else begin
            state <= RESTORE;
          end
        end
        RESTORE: begin
          case (group)
            `CRST_GRP_PSW: statusWord <= saved[7:0];
            `CRST_GRP_STACK: stackPointer <= saved;
            // ext registers hold only the low nibble, so a restore masks too
            `CRST_GRP_CS: codeExtensionReg <= saved[7:0] & `CRST_EXT_MASK;
            `CRST_GRP_DEXT: dataExtensionReg <= saved[7:0] & `CRST_EXT_MASK;
            default: ;
          endcase
          patPhase <= 1'b0;
          if (group == `CRST_GRP_WORK && pairIdx != 4'hf) begin
            pairIdx <= pairIdx + 4'h1;
            state <= SAVE;
          end else begin
            state <= FINISH;
          end
        end
        FINISH: begin
          // result and fail flag stand until the next done
          accumulatorResult <= failSeen ? `CRST_RESULT_FAIL : `CRST_RESULT_PASS;
          testDone[group] <= 1'b1;
          testFail[group] <= failSeen;
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // crst_register_selftest

// [hw/crst_selftest_map.vh]
// constants for the register pattern self-test sequencer
// assumes plain verilog-2005 include by bare name
`ifndef CRST_SELFTEST_MAP_VH
`define CRST_SELFTEST_MAP_VH
// ----------------------------------------
// patterns
// ----------------------------------------
`define CRST_PAT16_A 16'h5555
`define CRST_PAT16_B 16'haaaa
`define CRST_PAT8_A 8'h55
`define CRST_PAT8_B 8'haa
`define CRST_PATX_A 8'h05
`define CRST_PATX_B 8'h0a
// ----------------------------------------
// group selects
// ----------------------------------------
`define CRST_GRP_WORK 3'h0
`define CRST_GRP_PSW 3'h1
`define CRST_GRP_STACK 3'h2
`define CRST_GRP_CS 3'h3
`define CRST_GRP_DEXT 3'h4
`define CRST_NUM_GRP 5
// ----------------------------------------
// register file
// ----------------------------------------
`define CRST_NUM_BANK 4
`define CRST_PAIRS_PER_BANK 4
`define CRST_WORK_ADDR_W 4
`define CRST_RESULT_PASS 8'h00
`define CRST_RESULT_FAIL 8'h01
`define CRST_EXT_MASK 8'h0f
`endif

// [hw/crst_work_regfile.v]
// working register pair store: 4 banks x 4 pairs of 16 bits
// assumes single clock clk_sys; read data registered, one cycle latency
`timescale 1ns/100ps
`include "crst_selftest_map.vh"
module crst_work_regfile (
  input wire clk_sys,
  input wire writeEn,
  input wire [3:0] writeAddr,
  input wire [15:0] writeData,
  input wire [3:0] readAddr,
  output reg [15:0] readData
);
  reg [15:0] mem [0:15];
  always @(posedge clk_sys) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule // crst_work_regfile

// [test/crst_caller_model.sv]
// caller side model raising start requests
// assumes the bench holds launch until busy is seen
`timescale 1ns/100ps
module crst_caller_model (
  input wire clk_sys,
  input wire busy,
  input wire breakDuty,
  input wire [4:0] launch,
  output reg [4:0] startReq,
  output reg intBlocked,
  output reg bankZeroSelect
);
  initial startReq = 5'h00;
  // duties are kept unless a scenario breaks them on purpose
  always @(negedge clk_sys) begin
    intBlocked <= !breakDuty;
    bankZeroSelect <= !breakDuty;
  end
  // only while idle: a start held through a run is raised once busy drops
  always @(negedge clk_sys) begin
    startReq <= busy ? 5'h00 : launch;
  end
endmodule // crst_caller_model

// [test/crst_register_selftest_properties.sv]
// checker for the register pattern self-test sequencer
// assumes one clock and an async active-low reset
`timescale 1ns/100ps
module crst_register_selftest_properties (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] startReq,
  input wire [4:0] testDone,
  input wire [4:0] testFail,
  input wire [7:0] accumulatorResult,
  input wire busy,
  input wire [7:0] statusWord,
  input wire [15:0] stackPointer,
  input wire [7:0] codeExtensionReg,
  input wire [7:0] dataExtensionReg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // lowest request bit wins while idle
  wire [4:0] take = busy ? 5'h00 : (startReq & (~startReq + 5'h01));
  sequence pat(v, a, b);
    v == a ##[1:4] v == b;
  endsequence
  psw_order_a: assert property (take[1] |-> ##[1:4] pat(statusWord, 8'h55, 8'haa))
    else $error("status word order");
  stack_order_a: assert property (take[2] |->
    ##[1:4] pat(stackPointer, 16'h5555, 16'haaaa))
    else $error("stack pointer order");
  stack_restore_a: assert property (testDone[2] |-> stackPointer == $past(stackPointer, 10))
    else $error("stack pointer restore");
  cs_order_a: assert property (take[3] |-> ##[1:4] pat(codeExtensionReg, 8'h05, 8'h0a))
    else $error("code ext order");
  dext_order_a: assert property (take[4] |-> ##[1:4] pat(dataExtensionReg, 8'h05, 8'h0a))
    else $error("data ext order");
  ext_nibble_a: assert property (codeExtensionReg[7:4] == 4'h0 &&
    dataExtensionReg[7:4] == 4'h0)
    else $error("ext upper nibble set");
  done_latency_a: assert property (|take[4:1] |-> ##10 testDone == $past(take, 10))
    else $error("done latency");
  work_latency_a: assert property (take[0] |-> ##130 testDone == 5'h01)
    else $error("work done latency");
  result_code_a: assert property (testDone != 5'h00 |->
    accumulatorResult == {7'h00, |(testFail & testDone)})
    else $error("result code");
endmodule // crst_register_selftest_properties
bind crst_register_selftest crst_register_selftest_properties chk (.clk_sys, .rst_n, .startReq,
  .testDone, .testFail, .accumulatorResult, .busy, .statusWord, .stackPointer,
  .codeExtensionReg, .dataExtensionReg);

// [test/crst_tb.sv]
// self-checking bench for the register pattern self-test sequencer
// assumes the caller model keeps interrupts blocked and bank zero selected, except in the one broken-duty run
`timescale 1ns/100ps
module tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [4:0] launch = 5'h00;
  reg breakDuty = 1'b0;
  wire [4:0] startReq, testDone, testFail;
  wire [7:0] accumulatorResult, statusWord, codeExtensionReg, dataExtensionReg;
  wire [15:0] stackPointer;
  wire busy, intBlocked, bankZeroSelect;
  integer fails = 0;
  integer compares = 0;
  integer n;
  reg [1:0] saw;
  always #25 clk_sys = ~clk_sys;
  crst_caller_model caller (.clk_sys, .busy, .breakDuty, .launch, .startReq, .intBlocked,
    .bankZeroSelect);
  crst_register_selftest DUT (.clk_sys, .rst_n, .startReq, .intBlocked, .bankZeroSelect,
    .testDone, .testFail, .accumulatorResult, .busy, .statusWord, .stackPointer,
    .codeExtensionReg, .dataExtensionReg);
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  // pairs are internal, so group 0 shows zero here
  function [15:0] regOf(input [2:0] g);
    case (g)
      3'h1: regOf = {8'h00, statusWord};
      3'h2: regOf = stackPointer;
      3'h3: regOf = {8'h00, codeExtensionReg};
      3'h4: regOf = {8'h00, dataExtensionReg};
      default: regOf = 16'h0000;
    endcase
  endfunction
  task run(input [4:0] mask, input [4:0] rest, input [2:0] g, input [15:0] a, input [15:0] b,
    input [15:0] lat, input expFail);
    begin
      saw = 2'b00;
      @(posedge clk_sys);
      launch <= mask;
      @(negedge clk_sys);
      while (busy !== 1'b1) @(negedge clk_sys);
      launch <= rest;
      for (n = 1; testDone[g] !== 1'b1 && n < 200; n = n + 1) begin
        saw = saw | {regOf(g) === b, regOf(g) === a};
        @(negedge clk_sys);
      end
      check(n[15:0], lat);
      check({14'h0000, saw}, 16'h0003);
      check({11'h000, testDone}, 16'h0001 << g);
      check({8'h00, accumulatorResult}, {15'h0000, expFail});
      check({15'h0000, testFail[g]}, {15'h0000, expFail});
      check(regOf(g), 16'h0000);
    end
  endtask
  // reset in mid-test: outputs fall back to their reset values
  task run_reset;
    begin
      @(posedge clk_sys);
      launch <= 5'h04;
      @(negedge clk_sys);
      while (busy !== 1'b1) @(negedge clk_sys);
      launch <= 5'h00;
      repeat (2) @(negedge clk_sys);
      check(stackPointer, 16'h5555);
      rst_n = 1'b0;
      @(negedge clk_sys);
      check({10'h000, busy, testDone}, 16'h0000);
      check(stackPointer, 16'h0000);
      rst_n = 1'b1;
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    run(5'h01, 5'h00, 3'h0, 16'h0000, 16'h0000, 16'h0082, 1'b0);
    run(5'h02, 5'h00, 3'h1, 16'h0055, 16'h00aa, 16'h000a, 1'b0);
    run(5'h04, 5'h00, 3'h2, 16'h5555, 16'haaaa, 16'h000a, 1'b0);
    // two requests at once: code ext first, data ext retriggers
    run(5'h18, 5'h10, 3'h3, 16'h0005, 16'h000a, 16'h000a, 1'b0);
    run(5'h10, 5'h00, 3'h4, 16'h0005, 16'h000a, 16'h000a, 1'b0);
    run_reset;
    // caller duty broken on purpose: the result must say fail
    breakDuty <= 1'b1;
    run(5'h01, 5'h00, 3'h0, 16'h0000, 16'h0000, 16'h0082, 1'b1);
    breakDuty <= 1'b0;
    run(5'h02, 5'h00, 3'h1, 16'h0055, 16'h00aa, 16'h000a, 1'b0);
    report_and_stop;
  end
  initial begin
    #300000;
    fails = fails + 1;
    report_and_stop;
  end
endmodule // tb
